// >>> logic/sbpd_pkg.sv
package sbpd_pkg;

  // ----------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------
  localparam logic [3:0] OFS_SYSCTL = 4'h0;  // System control register
  localparam logic [3:0] OFS_MODSTP = 4'h4;  // Module stop register
  localparam logic [3:0] OFS_STATUS = 4'h8;  // Power state, read only

  // ----------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------
  localparam int BIT_RAM_EN  = 0;  // Ram enable bit
  localparam int BIT_HALT_D  = 0;  // Halt bit d, converter
  localparam int BIT_HALT_C  = 3;  // Halt bit c, serial b
  localparam int BIT_HALT_B  = 4;  // Halt bit b, serial a
  localparam int BIT_HALT_A  = 5;  // Halt bit a, timer unit
  localparam int BIT_CLK_DIS = 7;  // Clock output disable
  localparam logic [7:0] RST_SYSCTL = 8'h01;  // Ram enabled
  localparam logic [7:0] RST_MODSTP = 8'h00;  // All running
  localparam logic [7:0] HALT_RDATA = 8'hFF;  // Halted module read

  // ----------------------------------------------------------
  // Power states, one-hot
  // ----------------------------------------------------------
  typedef enum logic [5:0] {
    ST_HWSTBY = 6'b00_0001,  // Hardware standby
    ST_RESET  = 6'b00_0010,  // Oscillator running, held in reset
    ST_RSTEXC = 6'b00_0100,  // Reset exception handling
    ST_RUN    = 6'b00_1000,  // Program execution
    ST_SLEEP  = 6'b01_0000,  // Sleep
    ST_SWSTBY = 6'b10_0000   // Software standby
  } sbpd_state_t;

  // Peripheral register access from the cpu side
  typedef struct packed {
    logic       stb;    // Access strobe, one cycle
    logic       we;     // Write
    logic [1:0] mod;    // 0 timer, 1 serial a, 2 serial b, 3 converter
    logic [7:0] wdata;  // Write data
  } sbpd_preq_t;

  // Clock pin drive
  typedef struct packed {
    logic o;   // Pin level
    logic oe;  // Pin driven
  } sbpd_pin_t;

endpackage : sbpd_pkg

// >>> logic/sbpd_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sbpd_sync (
  // Clock and asynchronous clear
  input  wire logic clk,
  input  wire logic arst_n,
  // Level in and synchronised level out
  input  wire logic d,
  output logic      q
);
  logic meta_r;  // First stage, read only by q

  // ----------------------------------------------------------
  // Two flops; clear acts at once, release is synchronised
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sbpd_sync
`default_nettype wire

// >>> logic/sbpd_top.sv
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sbpd_top
  import sbpd_pkg::*;
#(
  parameter int NMOD = 4  // Number of haltable modules
) (
  // Clock and power-on reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Device pins
  input  wire logic             standby_pin_n,
  input  wire logic             reset_pin_n,
  // Cpu low-power requests, same clock
  input  wire logic             cpu_sleep_req,
  input  wire logic             cpu_swstby_req,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Peripheral register access
  input  wire sbpd_preq_t       preq,
  input  wire logic [NMOD*8-1:0] prdata_i,
  output logic      [NMOD-1:0]  pwe_o,
  output logic      [7:0]       pwdata_o,
  output logic      [7:0]       prdata_o,
  // Resets and power controls
  output logic                  cpu_rst_n_o,
  output logic                  rst_exc_o,
  output logic      [NMOD-1:0]  mod_rst_n_o,
  output logic      [NMOD-1:0]  mod_pin_own_o,
  output logic                  ram_en_o,
  output logic                  ram_retain_o,
  output logic                  port_hiz_o,
  output logic                  port_hold_o,
  output logic                  osc_run_o,
  // Clock output pin
  output sbpd_pin_t             clk_pin_o
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic        stby_arst_n;  // Standby pin or power-on reset
  logic        res_arst_n;   // Any reset source
  logic        stby_s;       // Standby pin, synchronised, high = run
  logic        res_s;        // Reset pin, synchronised
  sbpd_state_t state_r;      // Power state
  sbpd_state_t state_nxt;    // Next power state
  logic [7:0]  sysctl_r;     // System control register
  logic [7:0]  modstp_r;     // Module stop register
  logic [NMOD-1:0] halt;     // Halt bits in module order

  // Entry into standby or reset is asynchronous
  assign stby_arst_n = reset_n & standby_pin_n;
  assign res_arst_n  = stby_arst_n & reset_pin_n;

  sbpd_sync u_sync_stby (
    .clk    (clk),
    .arst_n (stby_arst_n),
    .d      (1'b1),
    .q      (stby_s)
  );

  sbpd_sync u_sync_res (
    .clk    (clk),
    .arst_n (res_arst_n),
    .d      (1'b1),
    .q      (res_s)
  );

  // Halt bits gathered in module index order
  assign halt = {modstp_r[BIT_HALT_D], modstp_r[BIT_HALT_C],
                 modstp_r[BIT_HALT_B], modstp_r[BIT_HALT_A]};

  // ----------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!stby_s) begin
      state_nxt = ST_HWSTBY;
    end else if (!res_s) begin
      state_nxt = ST_RESET;
    end else begin
      case (state_r)
        ST_HWSTBY: state_nxt = ST_RESET;
        ST_RESET:  state_nxt = ST_RSTEXC;
        ST_RSTEXC: state_nxt = ST_RUN;
        ST_RUN: begin
          if (cpu_swstby_req) begin
            state_nxt = ST_SWSTBY;
          end else if (cpu_sleep_req) begin
            state_nxt = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!cpu_sleep_req) begin
            state_nxt = ST_RUN;
          end
        end
        ST_SWSTBY: begin
          if (!cpu_swstby_req) begin
            state_nxt = ST_RUN;
          end
        end
        default: state_nxt = ST_RESET;
      endcase
    end
  end

  // State register; standby pin forces standby at once
  always_ff @(posedge clk or negedge stby_arst_n) begin
    if (!stby_arst_n) begin
      state_r <= ST_HWSTBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------
  logic wb_req;  // Request present
  logic wb_wr;   // Write taken at this edge
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
    end
  end

  // Read data captured with the ack; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req & ~wb_ack_o) begin
      case (wb_adr_i)
        OFS_SYSCTL: wb_dat_o <= {24'h00_0000, sysctl_r};
        OFS_MODSTP: wb_dat_o <= {24'h00_0000, modstp_r};
        OFS_STATUS: wb_dat_o <= {26'h000_0000, state_r};
        default:    wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // System control register, reset to RST_SYSCTL by any reset source
  always_ff @(posedge clk or negedge res_arst_n) begin
    if (!res_arst_n) begin
      sysctl_r <= RST_SYSCTL;
    end else if (wb_wr && wb_adr_i == OFS_SYSCTL) begin
      sysctl_r <= wb_dat_i[7:0];
    end
  end

  // Module stop register; takes effect at the write's ack edge
  always_ff @(posedge clk or negedge res_arst_n) begin
    if (!res_arst_n) begin
      modstp_r <= RST_MODSTP;
    end else if (wb_wr && wb_adr_i == OFS_MODSTP) begin
      modstp_r <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------
  // Resets and power controls
  // ----------------------------------------------------------
  logic in_run;   // Cpu released from reset
  logic mods_off; // All supporting modules stopped
  assign in_run   = state_r[3] | state_r[4] | state_r[5];
  assign mods_off = state_r[0] | state_r[1] | state_r[5];

  // Cpu reset and exception pulse
  always_ff @(posedge clk or negedge res_arst_n) begin
    if (!res_arst_n) begin
      cpu_rst_n_o <= 1'b0;
      rst_exc_o   <= 1'b0;
    end else begin
      cpu_rst_n_o <= in_run | (state_r == ST_RSTEXC);
      rst_exc_o   <= (state_r == ST_RSTEXC);
    end
  end

  // Module resets: halt bit or power state; next bus cycle
  always_ff @(posedge clk or negedge res_arst_n) begin
    if (!res_arst_n) begin
      mod_rst_n_o   <= '0;
      mod_pin_own_o <= '0;
    end else begin
      mod_rst_n_o   <= ~halt & {NMOD{~mods_off}};
      mod_pin_own_o <= ~halt & {NMOD{in_run}};
    end
  end

  // Ram and port pin controls
  always_ff @(posedge clk or negedge stby_arst_n) begin
    if (!stby_arst_n) begin
      ram_en_o     <= 1'b0;
      ram_retain_o <= 1'b1;
      port_hiz_o   <= 1'b1;
      port_hold_o  <= 1'b0;
      osc_run_o    <= 1'b0;  // Oscillator stopped in hardware standby
    end else begin
      osc_run_o    <= (state_r != ST_SWSTBY) & stby_s;
      ram_en_o     <= sysctl_r[BIT_RAM_EN] & in_run;
      ram_retain_o <= (state_r == ST_HWSTBY);
      port_hiz_o   <= (state_r == ST_HWSTBY);
      port_hold_o  <= (state_r == ST_SWSTBY);
    end
  end

  // ----------------------------------------------------------
  // Peripheral access gating
  // ----------------------------------------------------------
  logic [7:0] prd_sel;  // Addressed module's read data
  logic       p_halt;   // Addressed module halted
  assign prd_sel = prdata_i[preq.mod*8 +: 8];
  assign p_halt  = halt[preq.mod] | mods_off;

  // Writes to a halted module are dropped; reads give all ones
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwe_o    <= '0;
      pwdata_o <= 8'h00;
      prdata_o <= HALT_RDATA;
    end else begin
      pwe_o <= '0;
      if (preq.stb & preq.we & ~p_halt) begin
        pwe_o[preq.mod] <= 1'b1;
      end
      pwdata_o <= preq.wdata;
      if (preq.stb & ~preq.we) begin
        prdata_o <= p_halt ? HALT_RDATA : prd_sel;
      end
    end
  end

  // ----------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------
  logic phi_r;  // Clock replica, toggles each rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phi_r <= 1'b0;
    end else begin
      phi_r <= ~phi_r;
    end
  end

  // Float when disabled or in hardware standby
  always_ff @(posedge clk or negedge stby_arst_n) begin
    if (!stby_arst_n) begin
      clk_pin_o <= '{o: 1'b0, oe: 1'b0};
    end else if (modstp_r[BIT_CLK_DIS] || state_r == ST_HWSTBY) begin
      clk_pin_o <= '{o: 1'b0, oe: 1'b0};
    end else if (state_r == ST_SWSTBY) begin
      clk_pin_o <= '{o: 1'b1, oe: 1'b1};
    end else begin
      clk_pin_o <= '{o: ~phi_r, oe: 1'b1};
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  AST_HWSTBY_ENTRY: assert property (
    @(posedge clk) disable iff (!reset_n)
    !standby_pin_n |-> ##[0:3] state_r == ST_HWSTBY)
    else $error("Standby pin low without hardware standby");

  AST_HWSTBY_RESETS: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == ST_HWSTBY |=> !cpu_rst_n_o && mod_rst_n_o == '0)
    else $error("Module out of reset in hardware standby");

  AST_PORT_HIZ: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(state_r == ST_HWSTBY) |=> port_hiz_o && !clk_pin_o.oe)
    else $error("Ports driven in hardware standby");

  AST_HOLD_RESET: assert property (
    @(posedge clk) disable iff (!reset_n || !standby_pin_n)
    state_r == ST_RESET && !res_s |=> state_r == ST_RESET)
    else $error("Left reset while reset pin low");

  AST_RST_SEQ: assert property (
    @(posedge clk) disable iff (!reset_n || !standby_pin_n || !reset_pin_n)
    state_r == ST_RSTEXC |=> state_r == ST_RUN ##1 cpu_rst_n_o)
    else $error("Reset exception not followed by run");

  AST_HALT_TIMING: assert property (
    @(posedge clk) disable iff (!reset_n || !reset_pin_n || !standby_pin_n)
    $rose(modstp_r[BIT_HALT_A]) |=> !mod_rst_n_o[0] && !mod_pin_own_o[0])
    else $error("Halted timer not reset next cycle");

  AST_HALT_READ: assert property (
    @(posedge clk) disable iff (!reset_n)
    preq.stb && !preq.we && halt[preq.mod] |=> prdata_o == HALT_RDATA)
    else $error("Halted module read not all ones");

  AST_HALT_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    preq.stb && preq.we && halt[preq.mod] |=> pwe_o == '0)
    else $error("Write passed to halted module");

  AST_CLK_DIS: assert property (
    @(posedge clk) disable iff (!reset_n)
    modstp_r[BIT_CLK_DIS] |=> !clk_pin_o.oe)
    else $error("Clock pin driven while disabled");

  AST_SWSTBY_PINS: assert property (
    @(posedge clk) disable iff (!reset_n || !standby_pin_n)
    state_r == ST_SWSTBY && !modstp_r[BIT_CLK_DIS]
      |=> port_hold_o && clk_pin_o.o && clk_pin_o.oe)
    else $error("Software standby pins not held");

endmodule : sbpd_top
`default_nettype wire

// >>> verif/sbpd_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Supervisor sequencing standby and reset
// ----------------------------------------
module sbpd_supervisor #(
  parameter int SETTLE = 12  // Oscillator settling wait, cycles
) (
  // Clock and command
  input  wire logic clk,
  input  wire logic go_stby,
  // Device pins
  output logic      standby_pin_n,
  output logic      reset_pin_n
);
  // Power-up: reset low, standby high
  initial begin
    standby_pin_n = 1'b1;
    reset_pin_n   = 1'b0;
  end
  // Sequencer, changes just after an edge
  always begin
    @(posedge clk);
    if (go_stby && standby_pin_n) begin
      reset_pin_n <= 1'b0;
      @(posedge clk);
      standby_pin_n <= 1'b0;
    end else if (!go_stby && !reset_pin_n) begin
      standby_pin_n <= 1'b1;
      repeat (SETTLE) @(posedge clk);
      reset_pin_n <= 1'b1;
    end
  end
endmodule : sbpd_supervisor
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import sbpd_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, reset_n, go_stby, stby_n, rst_n;  // Clock, resets, pins
  logic        sleep_req, swstby_req;                 // Cpu requests
  logic        wb_cyc, wb_stb, wb_we, wb_ack;         // Bus control
  logic [3:0]  wb_adr;                                // Bus address
  logic [31:0] wb_dat, wb_rdat, rd;                   // Bus data
  sbpd_preq_t  preq;                                  // Peripheral access
  logic [3:0]  pwe, mrst_n, mown;                     // Module controls
  logic [7:0]  pwdata, prdata, pr;                    // Peripheral data
  logic        cpu_rst_n, rst_exc, ram_en, retain;    // Power outputs
  logic        hiz, hold, osc_run;                    // Port and oscillator
  sbpd_pin_t   cpin;                                  // Clock pin
  logic [3:0]  pw;                                    // Seen write strobes
  logic        o1;                                    // Clock pin sample
  int          n_mismatch = 0, comparisons = 0, n_exc = 0;
  int          pos[4] = '{BIT_HALT_A, BIT_HALT_B, BIT_HALT_C, BIT_HALT_D};
  localparam logic [31:0] PRD = 32'h4433_2211;        // Module read data

  sbpd_supervisor i_sup (.clk(clk), .go_stby(go_stby), .standby_pin_n(stby_n),
                         .reset_pin_n(rst_n));
  sbpd_top i_dut (.clk(clk), .reset_n(reset_n), .standby_pin_n(stby_n), .reset_pin_n(rst_n),
    .cpu_sleep_req(sleep_req), .cpu_swstby_req(swstby_req), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .preq(preq), .prdata_i(PRD),
    .pwe_o(pwe), .pwdata_o(pwdata), .prdata_o(prdata), .cpu_rst_n_o(cpu_rst_n),
    .rst_exc_o(rst_exc), .mod_rst_n_o(mrst_n), .mod_pin_own_o(mown), .ram_en_o(ram_en),
    .ram_retain_o(retain), .port_hiz_o(hiz), .port_hold_o(hold), .osc_run_o(osc_run),
    .clk_pin_o(cpin));

  // ----------------------------------------
  // Clock, watchdog, exception pulse count
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  always @(posedge clk) if (rst_exc === 1'b1) n_exc++;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack seen
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] r);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer
  // One peripheral access, answer one cycle later
  task automatic pacc(input logic we, input logic [1:0] m, output logic [3:0] w,
                      output logic [7:0] r);
    @(posedge clk);
    preq <= '{stb: 1'b1, we: we, mod: m, wdata: 8'hA5};
    @(posedge clk);
    preq.stb <= 1'b0;
    #1;
    w = pwe;
    r = prdata;
  endtask : pacc
  task automatic wait_run();
    int t;
    t = 0;
    while (cpu_rst_n !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    repeat (2) @(posedge clk);
  endtask : wait_run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {reset_n, go_stby, sleep_req, swstby_req, wb_cyc, wb_stb, wb_we} = '0;
    wb_adr = 4'h0;
    wb_dat = 32'h0000_0000;
    preq = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    wait_run();
    chk(32'(cpu_rst_n), 32'h0000_0001);
    chk(32'(n_exc), 32'h0000_0001);
    wb_xfer(1'b0, OFS_STATUS, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0008);
    chk(32'(ram_en), 32'h0000_0001);
    wb_xfer(1'b0, 4'hC, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("test startup done");
    // Each halt bit alone
    for (int m = 0; m < 4; m++) begin
      wb_xfer(1'b1, OFS_MODSTP, 32'(1 << pos[m]), rd);
      repeat (2) @(posedge clk);
      chk(32'(mrst_n), 32'(4'hF & ~(4'h1 << m)));
      chk(32'(mown), 32'(4'hF & ~(4'h1 << m)));
      pacc(1'b1, 2'(m), pw, pr);
      chk(32'(pw), 32'h0000_0000);
      pacc(1'b0, 2'(m), pw, pr);
      chk(32'(pr), 32'h0000_00FF);
      wb_xfer(1'b1, OFS_MODSTP, 32'h0000_0000, rd);
      repeat (2) @(posedge clk);
      pacc(1'b1, 2'(m), pw, pr);
      chk(32'(pw), 32'(4'h1 << m));
      chk(32'(pwdata), 32'h0000_00A5);
      pacc(1'b0, 2'(m), pw, pr);
      chk(32'(pr), 32'(PRD[8*m +: 8]));
    end
    $display("test halt done");
    // Clock pin disable and enable
    wb_xfer(1'b1, OFS_MODSTP, 32'(1 << BIT_CLK_DIS), rd);
    repeat (3) @(posedge clk);
    chk(32'(cpin.oe), 32'h0000_0000);
    wb_xfer(1'b1, OFS_MODSTP, 32'h0000_0000, rd);
    repeat (3) @(posedge clk);
    o1 = cpin.o;
    @(posedge clk);
    chk({30'h0, cpin.oe, o1 ^ cpin.o}, 32'h0000_0003);
    $display("test clock pin done");
    // Sleep, then software standby, then hardware standby
    wb_xfer(1'b1, OFS_SYSCTL, 32'h0000_0000, rd);
    sleep_req <= 1'b1;
    repeat (6) @(posedge clk);
    wb_xfer(1'b0, OFS_STATUS, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0010);
    chk(32'(ram_en), 32'h0000_0000);
    o1 = cpin.o;
    @(posedge clk);
    chk({30'h0, cpin.oe, o1 ^ cpin.o}, 32'h0000_0003);
    sleep_req  <= 1'b0;
    swstby_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(hold), 32'h0000_0001);
    chk({30'h0, cpin}, 32'h0000_0003);
    go_stby <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({28'h0, hiz, retain, cpu_rst_n, cpin.oe}, 32'h0000_000C);
    chk(32'(mrst_n), 32'h0000_0000);
    @(posedge clk);
    {sleep_req, swstby_req, go_stby} <= 3'b000;
    repeat (8) @(posedge clk);
    chk({30'h0, osc_run, cpu_rst_n}, 32'h0000_0002);
    wait_run();
    chk(32'(n_exc), 32'h0000_0002);
    wb_xfer(1'b0, OFS_SYSCTL, 32'h0000_0000, rd);
    chk(rd, 32'(RST_SYSCTL));
    $display("test standby done");
    close_out();
  end
endmodule : tb
`default_nettype wire
